// File: src/smpc_controller.sv
// Sleep controller: mode gating, wake selection, wake delays, brown-out sleep-off.
// Assumes the core pulses sleep_instr and waits on core_hold; sources are async pins.
`timescale 1ns/100ps
`default_nettype none
`include "smpc_map.svh"
module smpc_controller
  import smpc_pkg::*;
#(
  parameter int unsigned STARTUP_CYC  = 16,
  parameter int unsigned BOD_WAKE_CYC = `SMPC_BOD_WAKE_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sleep_instr,
  input  wire logic        adc_enabled,
  input  wire logic        global_irq_en,
  input  wire logic        timer_async_select,
  input  wire logic        irq_pending,
  input  wire logic        adc_done_irq,
  input  wire logic        nvm_ready_irq,
  input  wire logic        async_timer_irq,
  input  wire logic        watchdog_irq,
  input  wire logic        start_cond_irq,
  input  wire logic        pin_change_irq,
  input  wire logic [1:0]  ext_irq_level,
  input  wire logic        any_reset,
  output logic             core_clock_en,
  output logic             program_memory_clock_en,
  output logic             peripheral_clock_en,
  output logic             converter_clock_en,
  output logic             async_timer_clock_en,
  output logic             main_osc_en,
  output logic             timer_osc_en,
  output logic             brownout_detector_en,
  output logic             adc_start,
  output logic             core_hold,
  output logic             restart_at_vector
);
  // Async pins: three flops, change counted when last two agree
  logic [2:0] rst_s_q;
  logic       rst_f_q;
  logic [9:0] src_s1_q, src_s2_q, src_s3_q, src_f_q;
  wire  [9:0] src_raw = {ext_irq_level, pin_change_irq, start_cond_irq, watchdog_irq,
                         async_timer_irq, nvm_ready_irq, adc_done_irq, irq_pending, 1'b0};
  always_ff @(posedge aclk) begin
    src_s1_q <= src_raw;
    src_s2_q <= src_s1_q;
    src_s3_q <= src_s2_q;
    rst_s_q  <= {rst_s_q[1:0], any_reset};
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_f_q <= 10'h000;
      rst_f_q <= 1'b0;
    end else begin
      for (int i = 0; i < 10; i++)
        if (src_s2_q[i] == src_s3_q[i]) src_f_q[i] <= src_s3_q[i];
      if (rst_s_q[1] == rst_s_q[2]) rst_f_q <= rst_s_q[2];
    end
  end
  wire irq_any   = src_f_q[1];
  wire adc_w     = src_f_q[2];
  wire nvm_w     = src_f_q[3];
  wire atim_w    = src_f_q[4];
  wire wdt_w     = src_f_q[5];
  wire start_w   = src_f_q[6];
  wire pinc_w    = src_f_q[7];
  wire [1:0] lvl = src_f_q[9:8];
  // Registers
  logic       sleep_enable_q;
  logic [1:0] sleep_mode_select_q;
  logic [1:0] ext_is_level_q;
  logic       timer_irq_mask_q;
  logic       brownout_sleep_off_q, brownout_sleep_unlock_q;
  logic [2:0] unlock_cnt_q;
  logic [1:0] brownout_sleep_off_cnt_q;
  smpc_state_t state_q;
  smpc_mode_t  mode_q;
  logic        bod_off_q;
  logic [31:0] wait_q;
  logic        by_reset_q;
  // AXI write path
  logic        aw_hold_q, w_hold_q;
  logic [11:0] aw_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire do_wr   = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire wr_ok   = aw_q == `SMPC_SLEEP_CTRL_OFS || aw_q == `SMPC_CORE_CTRL_OFS ||
                 aw_q == `SMPC_WAKE_CFG_OFS || aw_q == `SMPC_STATUS_OFS;
  wire wr_sc   = do_wr && aw_q == `SMPC_SLEEP_CTRL_OFS && ws_q[0];
  wire wr_cc   = do_wr && aw_q == `SMPC_CORE_CTRL_OFS && ws_q[0];
  wire wr_wc   = do_wr && aw_q == `SMPC_WAKE_CFG_OFS && ws_q[0];
  wire wb_brownout_sleep_off  = w_q[`SMPC_BROWNOUT_SLEEP_OFF_BIT];
  wire wb_brownout_sleep_unlock = w_q[`SMPC_BROWNOUT_SLEEP_UNLOCK_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_q          <= 12'h000;
      w_q           <= 32'h0000_0000;
      ws_q          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SMPC_AXI_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_q && !aw_take;
      s_axi_wready  <= !w_hold_q && !w_take;
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        aw_q      <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        w_q      <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `SMPC_AXI_OKAY : `SMPC_AXI_SLVERR;
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Sleep-off timed sequence
  wire unlock_open = unlock_cnt_q != 3'h0;
  wire brownout_sleep_off_set    = wr_cc && wb_brownout_sleep_off && !wb_brownout_sleep_unlock && unlock_open; // RULE_22
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_enable_q      <= 1'b0;
      sleep_mode_select_q <= 2'h0;
      ext_is_level_q      <= 2'h0;
      timer_irq_mask_q    <= 1'b0;
      brownout_sleep_off_q              <= 1'b0; // RULE_19
      brownout_sleep_unlock_q             <= 1'b0;
      unlock_cnt_q        <= 3'h0;
      brownout_sleep_off_cnt_q          <= 2'h0;
    end else begin
      if (wr_sc) begin
        sleep_enable_q      <= w_q[`SMPC_SE_BIT];
        sleep_mode_select_q <= w_q[`SMPC_SM_LSB +: 2];
      end
      if (wr_wc) begin
        ext_is_level_q   <= w_q[1:0];
        timer_irq_mask_q <= w_q[2];
      end
      if (wr_cc && wb_brownout_sleep_off && wb_brownout_sleep_unlock) begin
        unlock_cnt_q <= `SMPC_UNLOCK_WIN; // RULE_22
        brownout_sleep_unlock_q      <= 1'b1;
      end else if (unlock_open) begin
        unlock_cnt_q <= unlock_cnt_q - 3'h1;
        brownout_sleep_unlock_q      <= unlock_cnt_q != 3'h1;
      end
      if (brownout_sleep_off_set) begin
        brownout_sleep_off_q     <= 1'b1;
        brownout_sleep_off_cnt_q <= `SMPC_BROWNOUT_SLEEP_OFF_LIFE;
        brownout_sleep_unlock_q    <= 1'b0;
        unlock_cnt_q <= 3'h0;
      end else if (brownout_sleep_off_q) begin
        brownout_sleep_off_cnt_q <= brownout_sleep_off_cnt_q - 2'h1;
        if (brownout_sleep_off_cnt_q == 2'h1) brownout_sleep_off_q <= 1'b0; // RULE_23
      end
    end
  end
  // AXI read path
  wire [31:0] rd_mux =
    s_axi_araddr == `SMPC_SLEEP_CTRL_OFS ? {29'h0, sleep_mode_select_q, sleep_enable_q} :
    s_axi_araddr == `SMPC_CORE_CTRL_OFS  ? {25'h0, brownout_sleep_off_q, brownout_sleep_unlock_q, 5'h00} :
    s_axi_araddr == `SMPC_WAKE_CFG_OFS   ? {29'h0, timer_irq_mask_q, ext_is_level_q} :
    s_axi_araddr == `SMPC_STATUS_OFS     ? {26'h0, bod_off_q, by_reset_q, mode_q, state_q} :
    32'h0000_0000;
  wire rd_ok = s_axi_araddr == `SMPC_SLEEP_CTRL_OFS || s_axi_araddr == `SMPC_CORE_CTRL_OFS ||
               s_axi_araddr == `SMPC_WAKE_CFG_OFS || s_axi_araddr == `SMPC_STATUS_OFS;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SMPC_AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? `SMPC_AXI_OKAY : `SMPC_AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // Wake selection per mode
  wire ext_lvl_w  = |(lvl & ext_is_level_q); // RULE_12
  wire deep_wake  = wdt_w || start_w || pinc_w || ext_lvl_w; // RULE_11
  wire timer_wake = timer_async_select && timer_irq_mask_q && global_irq_en && atim_w; // RULE_13
  wire wake_src =
    mode_q == SMPC_IDLE     ? irq_any :                                 // RULE_09
    mode_q == SMPC_ADC_NR   ? deep_wake || adc_w || nvm_w || atim_w :   // RULE_10
    mode_q == SMPC_PWR_SAVE ? deep_wake || timer_wake :                 // RULE_05
    deep_wake;
  wire deep_mode  = sleep_mode_select_q[1];
  wire enter      = sleep_instr && sleep_enable_q && state_q == SMPC_RUN; // RULE_01 RULE_24
  wire osc_off    = mode_q == SMPC_PWR_DOWN || mode_q == SMPC_PWR_SAVE;
  // Hazard: a stopped oscillator needs its start-up period before the extra hold
  wire [31:0] start_len = osc_off ? STARTUP_CYC : 32'h1;
  // Sequencer. Memories are never touched here, so contents survive sleep. RULE_07
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= SMPC_RUN;
      mode_q     <= SMPC_IDLE;
      bod_off_q  <= 1'b0;
      wait_q     <= 32'h0;
      by_reset_q <= 1'b0;
      adc_start  <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      unique case (state_q)
        SMPC_RUN: begin
          if (enter) begin
            state_q    <= SMPC_SLEEP;
            mode_q     <= smpc_mode_t'(sleep_mode_select_q);
            bod_off_q  <= brownout_sleep_off_q && deep_mode; // RULE_16 RULE_17
            by_reset_q <= 1'b0;
            adc_start  <= adc_enabled && !deep_mode; // RULE_15
          end
        end
        SMPC_SLEEP: begin
          if (rst_f_q || wake_src) begin
            state_q    <= SMPC_START;
            by_reset_q <= rst_f_q; // RULE_08
            wait_q     <= start_len; // RULE_20
          end
        end
        SMPC_START: begin
          if (wait_q <= 32'h1) begin
            state_q   <= SMPC_HOLD;
            // Long detector settle replaces the short extra hold
            wait_q    <= bod_off_q ? BOD_WAKE_CYC : 32'(`SMPC_EXTRA_HOLD); // RULE_06 RULE_18
            bod_off_q <= 1'b0; // RULE_17
          end else begin
            wait_q <= wait_q - 32'h1;
          end
        end
        SMPC_HOLD: begin
          if (wait_q <= 32'h1) state_q <= SMPC_RUN;
          else wait_q <= wait_q - 32'h1;
        end
      endcase
    end
  end
  // Clock gating outputs
  wire sl = state_q == SMPC_SLEEP || state_q == SMPC_START;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_clock_en           <= 1'b1;
      program_memory_clock_en <= 1'b1;
      peripheral_clock_en     <= 1'b1;
      converter_clock_en      <= 1'b1;
      async_timer_clock_en    <= 1'b1;
      main_osc_en             <= 1'b1;
      timer_osc_en            <= 1'b1;
      brownout_detector_en    <= 1'b1;
      core_hold               <= 1'b0;
      restart_at_vector       <= 1'b0;
    end else begin
      core_clock_en           <= state_q == SMPC_RUN; // RULE_02
      program_memory_clock_en <= state_q == SMPC_RUN;
      peripheral_clock_en     <= !(sl && mode_q != SMPC_IDLE); // RULE_03
      converter_clock_en      <= !(sl && osc_off); // RULE_04
      async_timer_clock_en    <= !(sl && mode_q == SMPC_PWR_DOWN); // RULE_05
      timer_osc_en            <= !(sl && mode_q == SMPC_PWR_DOWN);
      main_osc_en             <= !(state_q == SMPC_SLEEP && osc_off);
      brownout_detector_en    <= !(state_q == SMPC_SLEEP && bod_off_q);
      core_hold               <= state_q != SMPC_RUN;
      restart_at_vector       <= state_q == SMPC_HOLD && by_reset_q;
    end
  end
  // Assertions
  a_enter_needs_se: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_24
    $rose(core_hold) |-> $past(sleep_enable_q, 2)) else $error("sleep entered without enable");
  a_idle_gating: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_02
    (state_q == SMPC_SLEEP && mode_q == SMPC_IDLE) |=> (!core_clock_en && peripheral_clock_en))
    else $error("idle gating wrong");
  a_nr_gating: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_03
    (state_q == SMPC_SLEEP && mode_q == SMPC_ADC_NR) |=> (!peripheral_clock_en && converter_clock_en))
    else $error("noise reduction gating wrong");
  a_pd_osc_off: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_04
    (state_q == SMPC_SLEEP && mode_q == SMPC_PWR_DOWN) |=> (!main_osc_en && !async_timer_clock_en))
    else $error("power-down clocks running");
  a_ps_async_on: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_05
    (state_q == SMPC_SLEEP && mode_q == SMPC_PWR_SAVE) |=> (async_timer_clock_en && !main_osc_en))
    else $error("power-save async clock stopped");
  a_bod_only_deep: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_16
    !brownout_detector_en |-> $past(mode_q == SMPC_PWR_DOWN || mode_q == SMPC_PWR_SAVE))
    else $error("detector off in shallow mode");
  a_brownout_sleep_off_clears: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_23
    $rose(brownout_sleep_off_q) |-> brownout_sleep_off_q [*3] ##1 !brownout_sleep_off_q) else $error("sleep-off not cleared after three");
  a_extra_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_06
    (state_q == SMPC_START && wait_q <= 32'h1 && !bod_off_q) |=>
      (state_q == SMPC_HOLD) [*4] ##1 state_q == SMPC_RUN) else $error("extra hold not four");
  a_reset_vector: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_08
    $rose(restart_at_vector) |-> $past(by_reset_q)) else $error("vector restart without reset");
  c_idle_trip: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == SMPC_SLEEP && mode_q == SMPC_IDLE ##[1:50] state_q == SMPC_RUN);
  c_pd_bod: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == SMPC_SLEEP && bod_off_q);
  c_reset_wake: cover property (@(posedge aclk) disable iff (!aresetn) $rose(restart_at_vector));
endmodule : smpc_controller
`default_nettype wire

// File: src/smpc_map.svh
// Constants for the sleep mode power controller: register offsets, fields, timing.
// Assumes one 200 MHz clock and an AXI4-Lite master with 32-bit data.
// Overview of operation
// RULE_01: Sleep only when sleep enable set and sleep instruction executes; mode from select.
// RULE_02: Mode 00 idle: gate core and program clocks, rest keeps running.
// RULE_03: Mode 01 converter noise reduction: gate peripheral, core and program clocks.
// RULE_04: Mode 10 power-down: stop main oscillator and all generated clocks.
// RULE_05: Mode 11 power-save: like power-down but async clock and timer oscillator run.
// RULE_06: Interrupt wake holds core four cycles beyond start-up, then resumes.
// RULE_07: Register file and SRAM stay unchanged across sleep.
// RULE_08: Reset during sleep wakes device and restarts at reset vector.
// RULE_09: In idle every enabled interrupt wakes the device.
// RULE_10: Noise reduction wakes only on listed converter, async, level and pin sources.
// RULE_11: Power-down wakes only on watchdog, start-condition, level and pin change.
// RULE_12: In deeper modes external lines wake only when set as level interrupts.
// RULE_13: Power-save with async timer: timer event wakes if both enables set.
// RULE_14: Software picks power-down when timer not on async clock.
// RULE_15: Entering idle or noise reduction with converter enabled starts a conversion.
// RULE_16: Brown-out sleep disable acts only in power-down and power-save.
// RULE_17: Disabled detector switches off at sleep entry, back on at wake.
// RULE_18: Wake after detector off holds execution about 60 us.
// RULE_19: Sleep-off bit disables detector when one; resets to zero.
// RULE_20: Power-down wake delayed by clock start-up time of clock source fuse.
// RULE_21: Level wake source holds its level long enough to be seen.
// RULE_22: Sleep-off set needs unlock write, then sleep-off write within four cycles.
// RULE_23: Sleep-off bit clears itself three cycles after set.
// RULE_24: Sleep instruction with sleep enable clear does nothing.
`ifndef SMPC_MAP_SVH
`define SMPC_MAP_SVH
`define SMPC_SLEEP_CTRL_OFS   12'h000
`define SMPC_CORE_CTRL_OFS    12'h004
`define SMPC_STATUS_OFS       12'h008
`define SMPC_WAKE_CFG_OFS     12'h00c
`define SMPC_SE_BIT           0
`define SMPC_SM_LSB           1
`define SMPC_BROWNOUT_SLEEP_OFF_BIT         6
`define SMPC_BROWNOUT_SLEEP_UNLOCK_BIT        5
`define SMPC_UNLOCK_WIN       3'h4
`define SMPC_BROWNOUT_SLEEP_OFF_LIFE        2'h3
`define SMPC_EXTRA_HOLD       3'h4
`define SMPC_BOD_WAKE_NS      60000
`define SMPC_CLK_NS           5
`define SMPC_BOD_WAKE_CYC     ((`SMPC_BOD_WAKE_NS + `SMPC_CLK_NS - 1) / `SMPC_CLK_NS)
`define SMPC_AXI_OKAY         2'h0
`define SMPC_AXI_SLVERR       2'h2
`endif

// File: src/smpc_pkg.sv
// Types for the sleep mode power controller.
// Assumes smpc_map.svh is compiled alongside.
package smpc_pkg;
  typedef enum logic [1:0] {
    SMPC_IDLE, SMPC_ADC_NR, SMPC_PWR_DOWN, SMPC_PWR_SAVE
  } smpc_mode_t;
  typedef enum logic [1:0] {
    SMPC_RUN, SMPC_SLEEP, SMPC_START, SMPC_HOLD
  } smpc_state_t;
endpackage : smpc_pkg

// File: tb/smpc_controller_bench.sv
// Bench for the sleep controller: registers, mode gating, wake filtering, wake delays.
// Assumes the package, map header and core model compile first.
`timescale 1ns/100ps
`default_nettype none
`include "smpc_map.svh"
module smpc_controller_bench;
  localparam int STARTUP = 16;
  localparam int BOD_CYC = 20;
  logic aclk = 1'b0, aresetn = 1'b0, sleep_req = 1'b0, sleep_instr;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic adc_enabled = 1'b0, global_irq_en = 1'b1, timer_async_select = 1'b1;
  logic [9:0] wake_req = 10'h000, wake_src;
  logic core_clock_en, program_memory_clock_en, peripheral_clock_en, converter_clock_en;
  logic async_timer_clock_en, main_osc_en, timer_osc_en, brownout_detector_en;
  logic adc_start, core_hold, restart_at_vector, hold_q = 1'b0, seen_rst = 1'b0;
  logic [7:0] clk_vec, rnd = 8'h12;
  logic [9:0] srcs [0:3] = '{10'h001, 10'h002, 10'h040, 10'h008};
  logic [34:0] q_rd [$];
  logic [1:0] q_b [$];
  logic [7:0] q_clk [$];
  logic q_wake [$];
  int n_mismatch = 0, comparisons = 0, n_adc = 0, n_adc_exp = 0;
  assign clk_vec = {core_clock_en, program_memory_clock_en, peripheral_clock_en, converter_clock_en,
                    async_timer_clock_en, main_osc_en, timer_osc_en, brownout_detector_en};

  smpc_controller #(.STARTUP_CYC(STARTUP), .BOD_WAKE_CYC(BOD_CYC)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sleep_instr(sleep_instr), .adc_enabled(adc_enabled), .global_irq_en(global_irq_en),
    .timer_async_select(timer_async_select), .irq_pending(wake_src[0]), .adc_done_irq(wake_src[1]),
    .nvm_ready_irq(wake_src[2]), .async_timer_irq(wake_src[3]), .watchdog_irq(wake_src[4]),
    .start_cond_irq(wake_src[5]), .pin_change_irq(wake_src[6]), .ext_irq_level(wake_src[8:7]),
    .any_reset(wake_src[9]), .core_clock_en(core_clock_en),
    .program_memory_clock_en(program_memory_clock_en), .peripheral_clock_en(peripheral_clock_en),
    .converter_clock_en(converter_clock_en), .async_timer_clock_en(async_timer_clock_en),
    .main_osc_en(main_osc_en), .timer_osc_en(timer_osc_en), .brownout_detector_en(brownout_detector_en),
    .adc_start(adc_start), .core_hold(core_hold), .restart_at_vector(restart_at_vector));

  smpc_core_model core (.aclk(aclk), .aresetn(aresetn), .core_hold(core_hold), .sleep_req(sleep_req),
    .wake_req(wake_req), .sleep_instr(sleep_instr), .wake_src(wake_src));

  initial forever #2.5 aclk = ~aclk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function automatic logic [7:0] exp_vec(input logic [1:0] m, input logic bo);
    case (m)
      2'h0: return 8'h3f;
      2'h1: return 8'h1f;
      2'h2: return {7'h00, ~bo};
      default: return {7'h05, ~bo};
    endcase
  endfunction : exp_vec

  task automatic check(input string what, input logic [33:0] e, input logic [33:0] got);
    comparisons++;
    if (got !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, e, got);
    end
  endtask : check

  task automatic results;
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    q_b.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [34:0] e);
    q_rd.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic go_sleep(input logic [1:0] m, input logic se, input logic bo);
    wr(`SMPC_SLEEP_CTRL_OFS, {29'h0, m, se}, `SMPC_AXI_OKAY);
    if (se) q_clk.push_back(exp_vec(m, bo));
    if (se && adc_enabled && !m[1]) n_adc_exp++;
    if (bo) begin
      wr(`SMPC_CORE_CTRL_OFS, 32'h60, `SMPC_AXI_OKAY);
      // Bit lives only three cycles, so sleep follows the response at once
      fork
        wr(`SMPC_CORE_CTRL_OFS, 32'h40, `SMPC_AXI_OKAY);
        begin
          // The unlock write's response may still stand in this step
          @(posedge aclk);
          wait (s_axi_bvalid);
          sleep_req <= 1'b1;
          @(posedge aclk);
          sleep_req <= 1'b0;
        end
      join
    end else begin
      sleep_req <= 1'b1;
      @(posedge aclk);
      sleep_req <= 1'b0;
    end
    repeat (4) @(posedge aclk);
    check("hold", se, core_hold);
  endtask : go_sleep

  task automatic wake(input logic [9:0] v, input logic ok, input int lo);
    int n;
    n = 0;
    repeat (rnd[2:0]) @(posedge aclk);
    rnd = lfsr(rnd);
    if (ok) q_wake.push_back(v[9]);
    wake_req <= v;
    while (core_hold && n < lo + 40) begin
      @(posedge aclk);
      n++;
    end
    wake_req <= 10'h000;
    check("wake", 1'b1, ok ? (n >= lo && n < lo + 40) : core_hold);
    repeat (12) @(posedge aclk);
  endtask : wake

  always @(posedge aclk) begin
    logic [34:0] e;
    hold_q <= core_hold;
    if (adc_start) n_adc++;
    if (s_axi_bvalid && s_axi_bready) check("bresp", q_b.size() ? q_b.pop_front() : 'x, s_axi_bresp);
    if (s_axi_rvalid && s_axi_rready) begin
      e = q_rd.size() ? q_rd.pop_front() : 'x;
      check("rdata", e[33:0], {s_axi_rresp, e[34] ? s_axi_rdata : e[31:0]});
    end
    if (core_hold && !hold_q) check("clocks", q_clk.size() ? q_clk.pop_front() : 'x, clk_vec);
    if (core_hold) seen_rst = seen_rst | restart_at_vector;
    if (!core_hold && hold_q) begin
      check("restart", q_wake.size() ? q_wake.pop_front() : 'x, seen_rst);
      check("clocks back", 8'hff, clk_vec);
      seen_rst = 1'b0;
    end
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    results();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check("clocks", 8'hff, clk_vec);
    rd(`SMPC_SLEEP_CTRL_OFS, {1'b1, `SMPC_AXI_OKAY, 32'h0});
    rd(`SMPC_CORE_CTRL_OFS, {1'b1, `SMPC_AXI_OKAY, 32'h0});
    rd(12'h010, {1'b0, `SMPC_AXI_SLVERR, 32'h0});
    wr(12'h010, 32'h1, `SMPC_AXI_SLVERR);
    wr(`SMPC_CORE_CTRL_OFS, 32'h40, `SMPC_AXI_OKAY);
    rd(`SMPC_CORE_CTRL_OFS, {1'b1, `SMPC_AXI_OKAY, 32'h0});
    go_sleep(2'h2, 1'b0, 1'b0);
    $display("test registers done");
    // Power-save only with the timer on its own clock
    wr(`SMPC_WAKE_CFG_OFS, 32'h4, `SMPC_AXI_OKAY);
    for (int m = 0; m < 4; m++) begin
      adc_enabled <= rnd[0];
      rnd = lfsr(rnd);
      go_sleep(m[1:0], 1'b1, 1'b0);
      wake(srcs[m], 1'b1, m[1] ? STARTUP + 4 : 4);
      check("conversions", n_adc_exp, n_adc);
    end
    $display("test modes done");
    go_sleep(2'h1, 1'b1, 1'b0);
    wake(10'h001, 1'b0, 0);
    wake(10'h004, 1'b1, 4);
    wr(`SMPC_WAKE_CFG_OFS, 32'h0, `SMPC_AXI_OKAY);
    go_sleep(2'h2, 1'b1, 1'b0);
    wake(10'h002, 1'b0, 0);
    wake(10'h080, 1'b0, 0);
    wake(10'h010, 1'b1, STARTUP + 4);
    wr(`SMPC_WAKE_CFG_OFS, 32'h1, `SMPC_AXI_OKAY);
    go_sleep(2'h3, 1'b1, 1'b0);
    wake(10'h080, 1'b1, STARTUP + 4);
    $display("test wake filter done");
    go_sleep(2'h2, 1'b1, 1'b1);
    wake(10'h020, 1'b1, BOD_CYC);
    go_sleep(2'h2, 1'b1, 1'b0);
    wake(10'h200, 1'b1, 1);
    $display("test brownout and reset wake done");
    results();
  end
endmodule : smpc_controller_bench
`default_nettype wire

// File: tb/smpc_core_model.sv
// Model of the core and the wake sources facing the sleep controller.
// Assumes the bench drives sleep_req and wake_req right after rising edges.
`timescale 1ns/100ps
`default_nettype none
module smpc_core_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       core_hold,
  input  wire logic       sleep_req,
  input  wire logic [9:0] wake_req,
  output logic            sleep_instr,
  output var logic [9:0]  wake_src
);
  logic [3:0] cnt_q;
  // A held core executes nothing, so no sleep instruction either
  assign sleep_instr = sleep_req & ~core_hold;
  // Sources stretched well past the synchroniser depth
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q    <= 4'h0;
      wake_src <= 10'h000;
    end else if (wake_req != 10'h000) begin
      cnt_q    <= 4'h8;
      wake_src <= wake_req;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else begin
      wake_src <= 10'h000;
    end
  end
endmodule : smpc_core_model
`default_nettype wire
